// ---- sfrpp_chk.sv ----
module sfrpp_chk #(
   parameter int OPEN_CYCLES = 32
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [7:0] rdata_o,
   input wire logic area_map_select_o,
   input wire logic [2:0] port_page_o,
   input wire logic [4:0] pll_n_divider_o,
   input wire logic watchdog_enable_bit_o,
   input wire logic protect_open_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************************
   // helper state
   // ***************************************************************
   logic [1:0] mode_q;
   logic [6:0] cnt_q;
   wire pw_wr = we_i && addr_i == sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER;
   wire ck_wr = we_i && addr_i == sfrpp_pkg::ADDR_CLKDIV;
   wire pg_wr = we_i && addr_i == sfrpp_pkg::ADDR_PGSEL;
   wire lock = mode_q == sfrpp_pkg::MODE_PROTECT && !protect_open_o;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mode_q <= sfrpp_pkg::RST_MODE;
      end else if (pw_wr && wdata_i[7:3] == sfrpp_pkg::PASS_MODE) begin
         mode_q <= wdata_i[1:0];
      end
   end
   // cycles the window has stood since the last open write
   always_ff @(posedge core_clk_i) begin
      if (rst_i || (pw_wr && wdata_i[7:3] == sfrpp_pkg::PASS_OPEN) || !protect_open_o) begin
         cnt_q <= 7'h00;
      end else begin
         cnt_q <= cnt_q + 7'h01;
      end
   end
   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_open;
      pw_wr && wdata_i[7:3] == sfrpp_pkg::PASS_OPEN && mode_q == sfrpp_pkg::MODE_PROTECT;
   endsequence
   sequence s_close;
      pw_wr && wdata_i[7:3] == sfrpp_pkg::PASS_CLOSE && mode_q == sfrpp_pkg::MODE_PROTECT;
   endsequence
   a_read_idle: assert property (!re_i |=> rdata_o == 8'h00)
      else $error("read data not idle");
   a_map_write: assert property (we_i && addr_i == sfrpp_pkg::ADDR_SYSCTL |=>
      area_map_select_o == $past(wdata_i[0])) else $error("map bit not written");
   a_sys_one: assert property (re_i && addr_i == sfrpp_pkg::ADDR_SYSCTL |=>
      rdata_o[2] == 1'b1) else $error("reserved one bit lost");
   a_page_manual: assert property (pg_wr && !area_map_select_o && !wdata_i[7] |=>
      port_page_o == $past(wdata_i[2:0])) else $error("manual page not taken");
   a_page_rsvd: assert property (re_i && addr_i == sfrpp_pkg::ADDR_PGSEL |=>
      rdata_o[7:3] == 5'h00) else $error("page upper bits not zero");
   a_open_hold: assert property (s_open |=> protect_open_o [*4])
      else $error("window did not open");
   a_close_now: assert property (s_close |=> !protect_open_o)
      else $error("window did not close");
   a_open_limit: assert property (protect_open_o |-> cnt_q < OPEN_CYCLES)
      else $error("window open too long");
   a_prot_block: assert property (ck_wr && lock |=> $stable(pll_n_divider_o))
      else $error("locked divider changed");
   a_prot_pass: assert property (ck_wr && !lock |=>
      pll_n_divider_o == $past(wdata_i[4:0])) else $error("open divider not written");
   a_wdt_hidden: assert property (we_i && addr_i == sfrpp_pkg::ADDR_WDTCON &&
      !area_map_select_o |=> $stable(watchdog_enable_bit_o)) else $error("wdt seen");
   a_page_hidden: assert property (pg_wr && area_map_select_o |=>
      $stable(port_page_o)) else $error("page seen in mapped area");
endmodule

// ---- sfrpp_cpu_model.sv ----
module sfrpp_cpu_model (
   input wire logic core_clk_i,
   input wire logic [7:0] rdata_i,
   output sfrpp_pkg::sfrpp_req_t req_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req_o = '0;
   // released bus shows inverted lines, never the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req_o <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      @(posedge core_clk_i);
      req_o <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~d};
      @(posedge core_clk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      req_o <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
      @(posedge core_clk_i);
      req_o <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: 8'hff};
      #1 d = rdata_i;
      @(posedge core_clk_i);
   endtask
   // map bit changed by and/or read-modify-write only
   task automatic set_map(input logic m);
      logic [7:0] v;
      rd(sfrpp_pkg::ADDR_SYSCTL, v);
      wr(sfrpp_pkg::ADDR_SYSCTL, m ? (v | 8'h01) : (v & 8'hfe));
   endtask
endmodule

// ---- sfrpp_page_unit.sv ----
module sfrpp_page_unit #(
   parameter int SLOTS = 4,
   parameter int PAGE_W = 3
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   output logic [PAGE_W-1:0] page_o
);
   localparam int SW = (SLOTS > 1) ? $clog2(SLOTS) : 1;

   generate
      if (SLOTS < 1 || SLOTS > 4 || PAGE_W < 1 || PAGE_W > 3) begin : g_bad
         $error("page unit parameters out of range");
      end
   endgenerate

   logic [PAGE_W-1:0] page_q;
   logic [PAGE_W-1:0] slot_q [SLOTS];

   wire [1:0] op = wdata_i[sfrpp_pkg::PG_OP_LSB +: 2];
   wire [SW-1:0] slot_sel = wdata_i[sfrpp_pkg::PG_STORAGE_SLOT_NUMBER_LSB +: SW];
   wire [PAGE_W-1:0] wr_page = wdata_i[sfrpp_pkg::PG_PAGE_LSB +: PAGE_W];
   wire do_save = wr_i && (op == sfrpp_pkg::OP_NEW_SAVE);
   wire do_rest = wr_i && (op == sfrpp_pkg::OP_RESTORE);
   // restore ignores the written page bits
   wire [PAGE_W-1:0] page_d = do_rest ? slot_q[slot_sel] : wr_page; // R8

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         page_q <= sfrpp_pkg::RST_PGSEL[PAGE_W-1:0];
         for (int i = 0; i < SLOTS; i++) begin
            slot_q[i] <= '0;
         end
      end else if (wr_i) begin
         page_q <= page_d; // R6 R7 R8
         if (do_save) begin
            slot_q[slot_sel] <= page_q; // R7
         end
      end
   end

   assign page_o = page_q;
endmodule

// ---- sfrpp_pkg.sv ----
package sfrpp_pkg;

   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [7:0] ADDR_SYSCTL = 8'h8f;
   localparam logic [7:0] ADDR_PROTECTION_PASSWORD_REGISTER = 8'hb3;
   localparam logic [7:0] ADDR_CLKDIV = 8'hb6;
   localparam logic [7:0] ADDR_PWRCTL = 8'hb7;
   localparam logic [7:0] ADDR_PGSEL = 8'hb2;
   localparam logic [7:0] ADDR_WDTCON = 8'hbb;
   localparam logic [7:0] ADDR_WDTREL = 8'hbc;
   localparam logic [7:0] ADDR_WDTWIN = 8'hbd;
   localparam logic [7:0] ADDR_WDTL = 8'hbe;
   localparam logic [7:0] ADDR_WDTH = 8'hbf;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int SYS_MAP_BIT = 0;
   localparam int SYS_ONE_BIT = 2;
   localparam int SYS_IMODE_BIT = 4;
   localparam int PG_PAGE_LSB = 0;
   localparam int PG_STORAGE_SLOT_NUMBER_LSB = 4;
   localparam int PG_OP_LSB = 6;
   localparam int PW_MODE_LSB = 0;
   localparam int PW_OPEN_BIT = 2;
   localparam int PW_PASS_LSB = 3;
   localparam int CLK_N_LSB = 0;
   localparam int CLK_K_LSB = 5;
   localparam int PWR_PD_BIT = 0;
   localparam int PWR_SD_BIT = 1;
   localparam int PWR_USER_BIT = 7;
   localparam int WDT_IN_BIT = 0;
   localparam int WDT_RS_BIT = 1;
   localparam int WDT_EN_BIT = 2;
   localparam int WDT_PR_BIT = 4;
   localparam int WDT_WINB_BIT = 5;

   // ***************************************************************
   // codes and reset values
   // ***************************************************************
   localparam logic [1:0] OP_NEW_SAVE = 2'h2;
   localparam logic [1:0] OP_RESTORE = 2'h3;
   localparam logic [1:0] MODE_PROTECT = 2'h3;
   localparam logic [4:0] PASS_OPEN = 5'h13;
   localparam logic [4:0] PASS_CLOSE = 5'h15;
   localparam logic [4:0] PASS_MODE = 5'h18;
   localparam logic [7:0] RST_SYSCTL = 8'h04;
   localparam logic [7:0] RST_PGSEL = 8'h00;
   localparam logic [1:0] RST_MODE = 2'h3;
   localparam logic [4:0] RST_N_DIV = 5'h00;
   localparam logic [2:0] RST_K_DIV = 3'h0;
   localparam logic [7:0] RST_WDT = 8'h00;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int PROT_OPEN_CORE_CLOCK_CYCLE = 32;
   localparam int PROT_OPEN_CYCLES = PROT_OPEN_CORE_CLOCK_CYCLE;

   typedef struct packed {
      logic we;
      logic re;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfrpp_req_t;

endpackage

// ---- sfrpp_protect_unit.sv ----
module sfrpp_protect_unit #(
   parameter int OPEN_CYCLES = sfrpp_pkg::PROT_OPEN_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic pw_we_i,
   input wire logic [7:0] pw_data_i,
   output logic [1:0] mode_o,
   output logic window_o,
   output logic wr_allow_o
);
   localparam int CW = $clog2(OPEN_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(OPEN_CYCLES - 1);

   generate
      if (OPEN_CYCLES < 1) begin : g_bad
         $error("open window must be at least one cycle");
      end
   endgenerate

   logic [1:0] mode_q;
   logic win_q;
   logic [CW-1:0] cnt_q;

   wire [4:0] pass = pw_data_i[sfrpp_pkg::PW_PASS_LSB +: 5];
   wire prot_on = (mode_q == sfrpp_pkg::MODE_PROTECT);
   wire open_hit = pw_we_i && prot_on && (pass == sfrpp_pkg::PASS_OPEN); // R11
   wire close_hit = pw_we_i && prot_on && (pass == sfrpp_pkg::PASS_CLOSE); // R12
   wire mode_hit = pw_we_i && (pass == sfrpp_pkg::PASS_MODE); // R14
   wire expire = win_q && (cnt_q == '0);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mode_q <= sfrpp_pkg::RST_MODE;
         win_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         if (mode_hit) begin
            mode_q <= pw_data_i[sfrpp_pkg::PW_MODE_LSB +: 2]; // R13 R14
         end
         if (open_hit) begin
            win_q <= 1'b1; // R16
            cnt_q <= LAST;
         end else if (close_hit || expire || mode_hit) begin
            win_q <= 1'b0; // R12 R15
            cnt_q <= '0;
         end else if (win_q) begin
            cnt_q <= cnt_q - CW'(1); // R15
         end
      end
   end

   assign mode_o = mode_q;
   assign window_o = win_q;
   assign wr_allow_o = !prot_on || win_q; // R10
endmodule

// ---- sfrpp_top.sv ----
// Operation
// R1 - map bit clear selects the standard area, set selects the mapped area
// R2 - reserved bit 2 of system control always reads one
// R3 - software changes map bit only by read-modify-write and/or
// R4 - 256 directly addressed locations, two overlapping areas chosen by map bit
// R5 - software programs the page field before touching paged registers
// R6 - operation 0x writes the page field directly, slot number ignored
// R7 - operation 10 loads new page and saves the old one to a slot
// R8 - operation 11 ignores written page and restores it from a slot
// R9 - page register bit 3 reads zero; operation and slot write-only
// R10 - protected bits are written only while access is open; the code also writes them whenever the mode is not 11
// R11 - in mode 11, pass code 10011 opens protected access
// R12 - in mode 11, pass code 10101 closes protected access
// R13 - open and close password writes leave the mode field unchanged
// R14 - mode field changes only when pass code is 11000
// R15 - opened access closes by itself after at most 32 cycles
// R16 - writing open code again restarts the 32-cycle count
// R17 - protected: n and k dividers, watchdog enable, power-down, slow-down
// R18 - watchdog registers only reachable in the mapped area
// R19 - port page register only reachable in the standard area
// R20 - blocked writes keep protected bits; unprotected bits still update
//
// Added by the designer: strobed register access.
module sfrpp_top #(
   parameter int OPEN_CYCLES = sfrpp_pkg::PROT_OPEN_CYCLES,
   parameter int PAGE_SLOTS = 4,
   parameter int PAGE_W = 3
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [7:0] rdata_o,
   input wire logic [15:0] wdt_count_i,
   input wire logic wdt_prewarn_i,
   output logic area_map_select_o,
   output logic [PAGE_W-1:0] port_page_o,
   output logic [4:0] pll_n_divider_o,
   output logic [2:0] pll_k_divider_o,
   output logic watchdog_enable_bit_o,
   output logic power_down_enable_o,
   output logic slow_down_enable_o,
   output logic wdt_in_select_o,
   output logic wdt_window_enable_o,
   output logic wdt_refresh_o,
   output logic [7:0] wdt_reload_o,
   output logic [7:0] wdt_window_o,
   output logic protect_open_o
);

   // ***************************************************************
   // request bundle
   // ***************************************************************
   sfrpp_pkg::sfrpp_req_t req;

   assign req.we = we_i;
   assign req.re = re_i;
   assign req.addr = addr_i;
   assign req.wdata = wdata_i;

   // ***************************************************************
   // state
   // ***************************************************************
   logic map_q;
   logic imode_q;
   logic [4:0] n_div_q;
   logic [2:0] k_div_q;
   logic pd_q;
   logic sd_q;
   logic pwr_user_q;
   logic wdt_in_q;
   logic wdt_en_q;
   logic wdt_winb_q;
   logic wdt_rs_q;
   logic [7:0] wdt_rel_q;
   logic [7:0] wdt_win_q;
   logic [7:0] rdata_q;

   // ***************************************************************
   // address decode
   // ***************************************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // both areas cover the same 256 offsets; the map bit picks one
   wire std_area = !map_q; // R1 R4
   wire map_area = map_q; // R1 R4

   // common registers answer in either area
   wire sel_sys = hit(req.addr, sfrpp_pkg::ADDR_SYSCTL);
   wire sel_pw = hit(req.addr, sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER);
   wire sel_clk = hit(req.addr, sfrpp_pkg::ADDR_CLKDIV);
   wire sel_pwr = hit(req.addr, sfrpp_pkg::ADDR_PWRCTL);

   wire sel_pg = std_area && hit(req.addr, sfrpp_pkg::ADDR_PGSEL); // R19

   wire sel_wcon = map_area && hit(req.addr, sfrpp_pkg::ADDR_WDTCON); // R18
   wire sel_wrel = map_area && hit(req.addr, sfrpp_pkg::ADDR_WDTREL); // R18
   wire sel_wwin = map_area && hit(req.addr, sfrpp_pkg::ADDR_WDTWIN); // R18
   wire sel_wl = map_area && hit(req.addr, sfrpp_pkg::ADDR_WDTL); // R18
   wire sel_wh = map_area && hit(req.addr, sfrpp_pkg::ADDR_WDTH); // R18

   wire wr_sys = req.we && sel_sys;
   wire wr_pw = req.we && sel_pw;
   wire wr_clk = req.we && sel_clk;
   wire wr_pwr = req.we && sel_pwr;
   wire wr_pg = req.we && sel_pg;
   wire wr_wcon = req.we && sel_wcon;
   wire wr_wrel = req.we && sel_wrel;
   wire wr_wwin = req.we && sel_wwin;

   // ***************************************************************
   // page register
   // ***************************************************************
   logic [PAGE_W-1:0] page;

   sfrpp_page_unit #(
      .SLOTS(PAGE_SLOTS),
      .PAGE_W(PAGE_W)
   ) u_page (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .wr_i(wr_pg),
      .wdata_i(req.wdata),
      .page_o(page)
   );

   // ***************************************************************
   // protection
   // ***************************************************************
   logic [1:0] prot_mode;
   logic prot_window;
   logic prot_allow;

   sfrpp_protect_unit #(
      .OPEN_CYCLES(OPEN_CYCLES)
   ) u_prot (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .pw_we_i(wr_pw),
      .pw_data_i(req.wdata),
      .mode_o(prot_mode),
      .window_o(prot_window),
      .wr_allow_o(prot_allow)
   );

   // a blocked write leaves only the guarded fields alone
   wire wr_clk_ok = wr_clk && prot_allow; // R10 R17 R20
   wire wr_pwr_ok = wr_pwr && prot_allow; // R10 R17 R20
   wire wr_wen_ok = wr_wcon && prot_allow; // R10 R17 R20

   // ***************************************************************
   // system control, clock and power
   // ***************************************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         map_q <= sfrpp_pkg::RST_SYSCTL[sfrpp_pkg::SYS_MAP_BIT];
         imode_q <= sfrpp_pkg::RST_SYSCTL[sfrpp_pkg::SYS_IMODE_BIT];
      end else if (wr_sys) begin
         map_q <= req.wdata[sfrpp_pkg::SYS_MAP_BIT]; // R1
         imode_q <= req.wdata[sfrpp_pkg::SYS_IMODE_BIT];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         n_div_q <= sfrpp_pkg::RST_N_DIV;
         k_div_q <= sfrpp_pkg::RST_K_DIV;
      end else if (wr_clk_ok) begin
         n_div_q <= req.wdata[sfrpp_pkg::CLK_N_LSB +: 5]; // R17
         k_div_q <= req.wdata[sfrpp_pkg::CLK_K_LSB +: 3]; // R17
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pd_q <= 1'b0;
         sd_q <= 1'b0;
      end else if (wr_pwr_ok) begin
         pd_q <= req.wdata[sfrpp_pkg::PWR_PD_BIT]; // R17
         sd_q <= req.wdata[sfrpp_pkg::PWR_SD_BIT]; // R17
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pwr_user_q <= 1'b0;
      end else if (wr_pwr) begin
         pwr_user_q <= req.wdata[sfrpp_pkg::PWR_USER_BIT]; // R20
      end
   end

   // ***************************************************************
   // watchdog registers
   // ***************************************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wdt_in_q <= 1'b0;
         wdt_winb_q <= 1'b0;
         wdt_rs_q <= 1'b0;
      end else begin
         // refresh request lasts one cycle
         wdt_rs_q <= wr_wcon && req.wdata[sfrpp_pkg::WDT_RS_BIT];
         if (wr_wcon) begin
            wdt_in_q <= req.wdata[sfrpp_pkg::WDT_IN_BIT]; // R20
            wdt_winb_q <= req.wdata[sfrpp_pkg::WDT_WINB_BIT]; // R20
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wdt_en_q <= 1'b0;
      end else if (wr_wen_ok) begin
         wdt_en_q <= req.wdata[sfrpp_pkg::WDT_EN_BIT]; // R17
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wdt_rel_q <= sfrpp_pkg::RST_WDT;
         wdt_win_q <= sfrpp_pkg::RST_WDT;
      end else begin
         if (wr_wrel) begin
            wdt_rel_q <= req.wdata;
         end
         if (wr_wwin) begin
            wdt_win_q <= req.wdata;
         end
      end
   end

   // ***************************************************************
   // read views
   // ***************************************************************
   wire [7:0] rv_sys = {3'h0, imode_q, 1'b0, 1'b1, 1'b0, map_q}; // R2
   wire [7:0] rv_pg = {4'h0, 1'b0, 3'(page)}; // R9
   wire [7:0] rv_pw = {5'h00, prot_window, prot_mode};
   wire [7:0] rv_clk = {k_div_q, n_div_q};
   wire [7:0] rv_pwr = {pwr_user_q, 5'h00, sd_q, pd_q};
   wire [7:0] rv_wcon = {2'h0, wdt_winb_q, wdt_prewarn_i, 1'b0,
                         wdt_en_q, wdt_rs_q, wdt_in_q};

   wire [7:0] rd_mux =
      sel_sys  ? rv_sys :
      sel_pg   ? rv_pg :
      sel_pw   ? rv_pw :
      sel_clk  ? rv_clk :
      sel_pwr  ? rv_pwr :
      sel_wcon ? rv_wcon :
      sel_wrel ? wdt_rel_q :
      sel_wwin ? wdt_win_q :
      sel_wl   ? wdt_count_i[7:0] :
      sel_wh   ? wdt_count_i[15:8] :
      8'h00;

   // data stand only in the cycle after the read strobe
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= req.re ? rd_mux : 8'h00;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign rdata_o = rdata_q;
   assign area_map_select_o = map_q;
   assign port_page_o = page;
   assign pll_n_divider_o = n_div_q;
   assign pll_k_divider_o = k_div_q;
   assign watchdog_enable_bit_o = wdt_en_q;
   assign power_down_enable_o = pd_q;
   assign slow_down_enable_o = sd_q;
   assign wdt_in_select_o = wdt_in_q;
   assign wdt_window_enable_o = wdt_winb_q;
   assign wdt_refresh_o = wdt_rs_q;
   assign wdt_reload_o = wdt_rel_q;
   assign wdt_window_o = wdt_win_q;
   assign protect_open_o = prot_window;

endmodule

// ---- tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OPEN = 32;
   logic core_clk_i;
   logic rst_i;
   logic [15:0] wcnt;
   logic prew;
   sfrpp_pkg::sfrpp_req_t req;
   logic [7:0] rdata;
   logic map;
   logic [2:0] pg;
   logic [4:0] nd;
   logic [2:0] kd;
   logic wen, pd, sd, opn;
   logic win, wwb, wrs;
   logic [7:0] wrel, wwin;
   int rs_cnt = 0;
   int err_count, n_checks, n;
   int seed = 32'hd334;
   logic [7:0] v, w;
   logic [2:0] page;
   logic [2:0] slots [4];
   sfrpp_top #(.OPEN_CYCLES(OPEN)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .addr_i(req.addr), .wdata_i(req.wdata), .we_i(req.we), .re_i(req.re),
      .rdata_o(rdata), .wdt_count_i(wcnt), .wdt_prewarn_i(prew),
      .area_map_select_o(map), .port_page_o(pg), .pll_n_divider_o(nd),
      .pll_k_divider_o(kd), .watchdog_enable_bit_o(wen), .power_down_enable_o(pd),
      .slow_down_enable_o(sd), .wdt_in_select_o(win), .wdt_window_enable_o(wwb),
      .wdt_refresh_o(wrs), .wdt_reload_o(wrel), .wdt_window_o(wwin), .protect_open_o(opn));
   sfrpp_cpu_model cpu (.core_clk_i(core_clk_i), .rdata_i(rdata), .req_o(req));
   // refresh pulses seen on the watchdog side
   always @(posedge core_clk_i) begin
      if (wrs === 1'b1) rs_cnt <= rs_cnt + 1;
   end
   // ***************************************************************
   // checking
   // ***************************************************************
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int exp);
      n_checks++;
      if (got != exp) begin
         err_count++;
         $display("mismatch t=%0t count %0d exp %0d", $time, got, exp);
      end
   endtask
   task automatic open_len();
      n = 0;
      #1;
      while (opn === 1'b1 && n < 100) begin
         @(posedge core_clk_i);
         #1 n++;
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ***************************************************************
   // stimulus
   // ***************************************************************
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   initial begin
      #100000;
      err_count++;
      conclude();
   end
   initial begin
      rst_i = 1'b1;
      wcnt = 16'h0000;
      prew = 1'b0;
      err_count = 0;
      n_checks = 0;
      page = 3'h0;
      foreach (slots[i]) slots[i] = 3'h0;
      repeat (8) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      cpu.rd(sfrpp_pkg::ADDR_SYSCTL, v); chk8(v, sfrpp_pkg::RST_SYSCTL);
      cpu.rd(sfrpp_pkg::ADDR_PGSEL, v); chk8(v, sfrpp_pkg::RST_PGSEL);
      cpu.rd(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, v); chk8(v, 8'h03);
      cpu.rd(8'h10, v); chk8(v, 8'h00);
      cpu.wr(sfrpp_pkg::ADDR_WDTREL, 8'h5a); chk8(wrel, 8'h00);
      cpu.set_map(1'b1); chk8({7'h00, map}, 8'h01);
      cpu.rd(sfrpp_pkg::ADDR_WDTREL, v); chk8(v, 8'h00);
      cpu.wr(sfrpp_pkg::ADDR_WDTREL, 8'h5a);
      cpu.rd(sfrpp_pkg::ADDR_WDTREL, v); chk8(v, 8'h5a);
      chk8(wrel, 8'h5a);
      w = 8'($random(seed));
      cpu.wr(sfrpp_pkg::ADDR_WDTWIN, w); chk8(wwin, w);
      cpu.rd(sfrpp_pkg::ADDR_WDTWIN, v); chk8(v, w);
      wcnt <= 16'($random(seed));
      prew <= 1'b1;
      cpu.rd(sfrpp_pkg::ADDR_WDTL, v); chk8(v, wcnt[7:0]);
      cpu.rd(sfrpp_pkg::ADDR_WDTH, v); chk8(v, wcnt[15:8]);
      cpu.rd(sfrpp_pkg::ADDR_WDTCON, v); chk8(v & 8'h10, 8'h10);
      cpu.wr(sfrpp_pkg::ADDR_WDTCON, 8'h27); chk8({5'h00, wwb, wen, win}, 8'h05);
      cpu.wr(sfrpp_pkg::ADDR_PGSEL, 8'h05); chk8({5'h00, pg}, 8'h00);
      cpu.set_map(1'b0); chk8({7'h00, map}, 8'h00);
      cpu.rd(sfrpp_pkg::ADDR_WDTREL, v); chk8(v, 8'h00);
      repeat (40) begin
         v = 8'($random(seed));
         if (v[7:6] == 2'b11) begin
            page = slots[v[5:4]];
         end else begin
            if (v[7]) slots[v[5:4]] = page;
            page = v[2:0];
         end
         cpu.wr(sfrpp_pkg::ADDR_PGSEL, v); chk8({5'h00, pg}, {5'h00, page});
         cpu.rd(sfrpp_pkg::ADDR_PGSEL, w); chk8(w, {5'h00, page});
      end
      cpu.wr(sfrpp_pkg::ADDR_CLKDIV, 8'hff); chk8({kd, nd}, 8'h00);
      cpu.wr(sfrpp_pkg::ADDR_PWRCTL, 8'h83);
      cpu.rd(sfrpp_pkg::ADDR_PWRCTL, v); chk8(v, 8'h80);
      cpu.wr(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, 8'h98);
      cpu.rd(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, v); chk8(v, 8'h07);
      v = 8'($random(seed));
      cpu.wr(sfrpp_pkg::ADDR_CLKDIV, v); chk8({kd, nd}, v);
      cpu.wr(sfrpp_pkg::ADDR_PWRCTL, 8'h03); chk8({6'h00, sd, pd}, 8'h03);
      cpu.wr(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, 8'ha8); chk8({7'h00, opn}, 8'h00);
      cpu.rd(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, w); chk8(w, 8'h03);
      cpu.wr(sfrpp_pkg::ADDR_CLKDIV, ~v); chk8({kd, nd}, v);
      cpu.wr(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, 8'h98);
      open_len(); chkn(n, OPEN - 1);
      cpu.wr(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, 8'h98);
      repeat (20) @(posedge core_clk_i);
      cpu.wr(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, 8'h98);
      open_len(); chkn(n, OPEN - 1);
      cpu.wr(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, 8'hc0);
      cpu.rd(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, v); chk8(v, 8'h00);
      v = 8'($random(seed));
      cpu.wr(sfrpp_pkg::ADDR_CLKDIV, v); chk8({kd, nd}, v);
      cpu.wr(sfrpp_pkg::ADDR_WDTCON, 8'h06); chk8({5'h00, wwb, wen, win}, 8'h05);
      cpu.wr(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, 8'hc3);
      cpu.rd(sfrpp_pkg::ADDR_PROTECTION_PASSWORD_REGISTER, v); chk8(v, 8'h03);
      chkn(rs_cnt, 1);
      conclude();
   end
endmodule
bind sfrpp_top sfrpp_chk #(.OPEN_CYCLES(OPEN_CYCLES)) u_chk (.core_clk_i(core_clk_i),
   .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
   .rdata_o(rdata_o), .area_map_select_o(area_map_select_o), .port_page_o(port_page_o),
   .pll_n_divider_o(pll_n_divider_o), .watchdog_enable_bit_o(watchdog_enable_bit_o),
   .protect_open_o(protect_open_o));
